// File: hdl/rfdrv_pkg.sv
package rfdrv_pkg;

   // Register offsets on the internal host register port.
   localparam logic [5:0] RECEIVE_MODE_OFS = 6'h13;
   localparam logic [5:0] DRIVER_CONTROL_OFS = 6'h14;
   localparam logic [5:0] MODULATION_FORCE_OFS = 6'h15;
   localparam logic [5:0] DRIVER_SOURCE_SELECT_OFS = 6'h16;

   // Values after reset.
   localparam logic [7:0] RECEIVE_MODE_RST = 8'h00;
   localparam logic [7:0] DRIVER_CONTROL_RST = 8'h80;
   localparam logic [7:0] MODULATION_FORCE_RST = 8'h00;
   localparam logic [7:0] DRIVER_SOURCE_SELECT_RST = 8'h10;

   // Implemented bits of each register; all others read as zero.
   localparam logic [7:0] RECEIVE_MODE_MASK = 8'h04;
   localparam logic [7:0] DRIVER_CONTROL_MASK = 8'hFB;
   localparam logic [7:0] MODULATION_FORCE_MASK = 8'h40;
   localparam logic [7:0] DRIVER_SOURCE_SELECT_MASK = 8'h3F;

   // Field positions.
   localparam int MULTI_FRAME_RECEIVE_BIT = 2;
   localparam int DRV2_INVERT_ON_BIT = 7;
   localparam int DRV1_INVERT_ON_BIT = 6;
   localparam int DRV2_INVERT_OFF_BIT = 5;
   localparam int DRV1_INVERT_OFF_BIT = 4;
   localparam int DRV2_CONTINUOUS_CARRIER_BIT = 3;
   localparam int DRV2_ENABLE_BIT = 1;
   localparam int DRV1_ENABLE_BIT = 0;
   localparam int FORCE_FULL_ASK_BIT = 6;
   localparam int DRIVER_SOURCE_LSB = 4;
   localparam int AUX_OUTPUT_SOURCE_LSB = 0;

   // Driver source codes.
   localparam logic [1:0] DRV_SRC_HIZ = 2'h0;
   localparam logic [1:0] DRV_SRC_MILLER = 2'h1;
   localparam logic [1:0] DRV_SRC_AUX_IN = 2'h2;
   localparam logic [1:0] DRV_SRC_HIGH = 2'h3;

   // Auxiliary output source codes.
   localparam logic [3:0] AUX_SRC_HIZ = 4'h0;
   localparam logic [3:0] AUX_SRC_LOW = 4'h1;
   localparam logic [3:0] AUX_SRC_HIGH = 4'h2;
   localparam logic [3:0] AUX_SRC_TEST_BUS = 4'h3;
   localparam logic [3:0] AUX_SRC_MILLER = 4'h4;
   localparam logic [3:0] AUX_SRC_TX_SERIAL = 4'h5;
   localparam logic [3:0] AUX_SRC_RX_DECODED = 4'h7;

   // Device revisions selecting the content of the appended error byte.
   localparam logic REVISION_1_0 = 1'b0;
   localparam logic REVISION_2_0 = 1'b1;

endpackage

// File: hdl/rfdrv_antenna_pin.sv
`timescale 1ns/1ps

// Computes the level and drive enable of one antenna driver pin.
module rfdrv_antenna_pin (
   input wire logic enable_in,
   input wire logic invert_on_in,
   input wire logic invert_off_in,
   input wire logic continuous_in,
   input wire logic [1:0] source_in,
   input wire logic miller_env_in,
   input wire logic aux_env_in,
   output logic level_out,
   output logic oe_out
);

   logic envelope;
   logic base;

   always_comb begin
      unique case (source_in)
         rfdrv_pkg::DRV_SRC_HIZ: envelope = 1'b0;
         rfdrv_pkg::DRV_SRC_MILLER: envelope = miller_env_in;
         rfdrv_pkg::DRV_SRC_AUX_IN: envelope = aux_env_in;
         rfdrv_pkg::DRV_SRC_HIGH: envelope = 1'b1;
      endcase
      // A disabled driver carries no carrier; an enabled one carries the envelope, or the steady carrier while continuous_in is set.
      base = enable_in ? (continuous_in | envelope) : 1'b0;
      level_out = base ^ (enable_in ? invert_on_in : invert_off_in);
      // Power-down does not change the drive: only source code 00 releases the pin.
      oe_out = (source_in != rfdrv_pkg::DRV_SRC_HIZ);
   end

endmodule

// File: hdl/rfdrv_regs.sv
`timescale 1ns/1ps

// Contract
// - With multi-frame receive clear, receiver turns off after one complete frame.
// - With multi-frame receive set, receiver keeps accepting frames; only above 106 kBd. The code has no rate input and allows it at any rate.
// - Multi-frame reception ends only by a non-receive command or clearing the bit.
// - With multi-frame set, an error-register copy byte is appended after each frame.
// - Error byte CRC position holds CRC-good on revision 2.0, CRC-fail on 1.0.
// - Bits 7 and 6 invert drivers two and one while enabled.
// - Bits 5 and 4 invert drivers two and one while disabled.
// - Bit 3 makes driver two send the unmodulated carrier continuously.
// - Bits 1 and 0 enable drivers two and one with modulated carrier.
// - Modulation bit 6 forces full-depth ASK, ignoring the modulation width setting.
// - Driver source 00 high impedance, 01 Miller envelope, 10 auxiliary input envelope.
// - In soft power-down drivers float only when driver source is 00.
// - Driver source 11 drives static high, then each pin's inversion bits apply; here high only while the pin is enabled, low while disabled.
// - Auxiliary output source selects high impedance, Miller envelope, decoded receive data.
module rfdrv_regs #(
   parameter logic DEVICE_REVISION = rfdrv_pkg::REVISION_2_0,
   parameter int CRC_BIT_POS = 2
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [5:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic rx_start_in,
   input wire logic rx_frame_end_in,
   input wire logic command_write_in,
   input wire logic command_is_receive_in,
   input wire logic [7:0] error_register_in,
   input wire logic crc_good_flag_in,
   input wire logic crc_fail_flag_in,
   input wire logic soft_powerdown_in,
   input wire logic miller_env_in,
   input wire logic aux_envelope_in,
   input wire logic tx_serial_in,
   input wire logic rx_decoded_in,
   input wire logic test_bus_in,
   output logic rx_enable_out,
   output logic rx_done_out,
   output logic fifo_push_out,
   output logic [7:0] fifo_data_out,
   output logic force_full_ask_out,
   output logic antenna_drive_1_out,
   output logic antenna_drive_1_oe_out,
   output logic antenna_drive_2_out,
   output logic antenna_drive_2_oe_out,
   output logic aux_out_pin_out,
   output logic aux_out_pin_oe_out
);

   typedef struct packed {
      logic multi_frame_receive;
      logic [7:0] driver_control;
      logic force_full_ask;
      logic [5:0] source_select;
      logic rx_active;
      logic aux_env_meta;
      logic aux_env_sync;
      logic [7:0] rdata;
      logic rx_done;
      logic fifo_push;
      logic [7:0] fifo_data;
      logic drv1;
      logic drv1_oe;
      logic drv2;
      logic drv2_oe;
      logic aux;
      logic aux_oe;
   } rfdrv_state_s;

   rfdrv_state_s state_q;
   rfdrv_state_s state_d;
   logic drv1_level;
   logic drv1_oe;
   logic drv2_level;
   logic drv2_oe;
   logic [1:0] driver_source;
   logic [3:0] aux_output_source;

   // Register write with reserved bits dropped and read with them forced to zero.
   function automatic logic [7:0] masked(input logic [7:0] value, input logic [7:0] mask);
      masked = value & mask;
   endfunction

   assign driver_source = state_q.source_select[rfdrv_pkg::DRIVER_SOURCE_LSB +: 2];
   assign aux_output_source = state_q.source_select[rfdrv_pkg::AUX_OUTPUT_SOURCE_LSB +: 4];

   rfdrv_antenna_pin u_pin1 (
      .enable_in(state_q.driver_control[rfdrv_pkg::DRV1_ENABLE_BIT]),
      .invert_on_in(state_q.driver_control[rfdrv_pkg::DRV1_INVERT_ON_BIT]),
      .invert_off_in(state_q.driver_control[rfdrv_pkg::DRV1_INVERT_OFF_BIT]),
      .continuous_in(1'b0),
      .source_in(driver_source),
      .miller_env_in(miller_env_in),
      .aux_env_in(state_q.aux_env_sync),
      .level_out(drv1_level),
      .oe_out(drv1_oe)
   );

   rfdrv_antenna_pin u_pin2 (
      .enable_in(state_q.driver_control[rfdrv_pkg::DRV2_ENABLE_BIT]),
      .invert_on_in(state_q.driver_control[rfdrv_pkg::DRV2_INVERT_ON_BIT]),
      .invert_off_in(state_q.driver_control[rfdrv_pkg::DRV2_INVERT_OFF_BIT]),
      .continuous_in(state_q.driver_control[rfdrv_pkg::DRV2_CONTINUOUS_CARRIER_BIT]),
      .source_in(driver_source),
      .miller_env_in(miller_env_in),
      .aux_env_in(state_q.aux_env_sync),
      .level_out(drv2_level),
      .oe_out(drv2_oe)
   );

   always_comb begin
      logic [7:0] err_byte;
      logic [7:0] rx_mode_wr;
      logic stop_rx;
      err_byte = error_register_in;
      rx_mode_wr = 8'h00;
      stop_rx = 1'b0;
      state_d = state_q;
      state_d.rx_done = 1'b0;
      state_d.fifo_push = 1'b0;
      state_d.aux_env_meta = aux_envelope_in;
      state_d.aux_env_sync = state_q.aux_env_meta;

      if (reg_wr_in) begin
         unique case (reg_addr_in)
            rfdrv_pkg::RECEIVE_MODE_OFS: begin
               rx_mode_wr = masked(reg_wdata_in, rfdrv_pkg::RECEIVE_MODE_MASK);
               state_d.multi_frame_receive = rx_mode_wr[rfdrv_pkg::MULTI_FRAME_RECEIVE_BIT];
            end
            rfdrv_pkg::DRIVER_CONTROL_OFS: begin
               state_d.driver_control = masked(reg_wdata_in, rfdrv_pkg::DRIVER_CONTROL_MASK);
            end
            rfdrv_pkg::MODULATION_FORCE_OFS: begin
               state_d.force_full_ask = reg_wdata_in[rfdrv_pkg::FORCE_FULL_ASK_BIT];
            end
            rfdrv_pkg::DRIVER_SOURCE_SELECT_OFS: begin
               state_d.source_select = reg_wdata_in[5:0];
            end
            default: begin
            end
         endcase
      end

      state_d.rdata = 8'h00;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            rfdrv_pkg::RECEIVE_MODE_OFS: begin
               state_d.rdata[rfdrv_pkg::MULTI_FRAME_RECEIVE_BIT] = state_q.multi_frame_receive;
            end
            rfdrv_pkg::DRIVER_CONTROL_OFS: begin
               state_d.rdata = masked(state_q.driver_control, rfdrv_pkg::DRIVER_CONTROL_MASK);
            end
            rfdrv_pkg::MODULATION_FORCE_OFS: begin
               state_d.rdata[rfdrv_pkg::FORCE_FULL_ASK_BIT] = state_q.force_full_ask;
            end
            rfdrv_pkg::DRIVER_SOURCE_SELECT_OFS: begin
               state_d.rdata = masked({2'b00, state_q.source_select},
                  rfdrv_pkg::DRIVER_SOURCE_SELECT_MASK);
            end
            default: begin
            end
         endcase
      end

      // Error byte carries the live CRC status of the coprocessor for this revision.
      if (DEVICE_REVISION == rfdrv_pkg::REVISION_2_0) begin
         err_byte[CRC_BIT_POS] = crc_good_flag_in;
      end else begin
         err_byte[CRC_BIT_POS] = crc_fail_flag_in;
      end

      if (state_q.rx_active && rx_frame_end_in) begin
         if (state_q.multi_frame_receive) begin
            state_d.fifo_push = 1'b1;
            state_d.fifo_data = err_byte;
         end else begin
            stop_rx = 1'b1;
         end
      end
      // Multi-frame reception never ends on its own, only on these host actions.
      if (command_write_in && !command_is_receive_in) begin
         stop_rx = 1'b1;
      end
      if (reg_wr_in && reg_addr_in == rfdrv_pkg::RECEIVE_MODE_OFS &&
          !rx_mode_wr[rfdrv_pkg::MULTI_FRAME_RECEIVE_BIT]) begin
         stop_rx = stop_rx | state_q.multi_frame_receive;
      end
      if (stop_rx && state_q.rx_active) begin
         state_d.rx_active = 1'b0;
         state_d.rx_done = 1'b1;
      end
      // A new start in the same cycle as a stop wins and keeps the receiver on.
      if (rx_start_in) begin
         state_d.rx_active = 1'b1;
         state_d.rx_done = 1'b0;
      end

      state_d.drv1 = drv1_level;
      state_d.drv1_oe = drv1_oe && !(soft_powerdown_in && driver_source ==
         rfdrv_pkg::DRV_SRC_HIZ);
      state_d.drv2 = drv2_level;
      state_d.drv2_oe = drv2_oe && !(soft_powerdown_in && driver_source ==
         rfdrv_pkg::DRV_SRC_HIZ);

      state_d.aux_oe = 1'b1;
      unique case (aux_output_source)
         rfdrv_pkg::AUX_SRC_LOW: state_d.aux = 1'b0;
         rfdrv_pkg::AUX_SRC_HIGH: state_d.aux = 1'b1;
         rfdrv_pkg::AUX_SRC_TEST_BUS: state_d.aux = test_bus_in;
         rfdrv_pkg::AUX_SRC_MILLER: state_d.aux = miller_env_in;
         rfdrv_pkg::AUX_SRC_TX_SERIAL: state_d.aux = tx_serial_in;
         rfdrv_pkg::AUX_SRC_RX_DECODED: state_d.aux = rx_decoded_in;
         default: begin
            // High impedance for code 0000 and every reserved code.
            state_d.aux = 1'b0;
            state_d.aux_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state_q <= '0;
         state_q.multi_frame_receive <=
            rfdrv_pkg::RECEIVE_MODE_RST[rfdrv_pkg::MULTI_FRAME_RECEIVE_BIT];
         state_q.driver_control <= rfdrv_pkg::DRIVER_CONTROL_RST;
         state_q.force_full_ask <=
            rfdrv_pkg::MODULATION_FORCE_RST[rfdrv_pkg::FORCE_FULL_ASK_BIT];
         state_q.source_select <= rfdrv_pkg::DRIVER_SOURCE_SELECT_RST[5:0];
      end else begin
         state_q <= state_d;
      end
   end

   assign reg_rdata_out = state_q.rdata;
   assign rx_enable_out = state_q.rx_active;
   assign rx_done_out = state_q.rx_done;
   assign fifo_push_out = state_q.fifo_push;
   assign fifo_data_out = state_q.fifo_data;
   assign force_full_ask_out = state_q.force_full_ask;
   assign antenna_drive_1_out = state_q.drv1;
   assign antenna_drive_1_oe_out = state_q.drv1_oe;
   assign antenna_drive_2_out = state_q.drv2;
   assign antenna_drive_2_oe_out = state_q.drv2_oe;
   assign aux_out_pin_out = state_q.aux;
   assign aux_out_pin_oe_out = state_q.aux_oe;

endmodule

// File: dv/rfdrv_regs_sva.sv
`timescale 1ns/1ps
module rfdrv_regs_sva #(
   parameter logic DEVICE_REVISION = 1'b1,
   parameter int CRC_BIT_POS = 2
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [5:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic rx_start_in,
   input wire logic rx_frame_end_in,
   input wire logic command_write_in,
   input wire logic command_is_receive_in,
   input wire logic [7:0] error_register_in,
   input wire logic crc_good_flag_in,
   input wire logic crc_fail_flag_in,
   input wire logic rx_enable_out,
   input wire logic rx_done_out,
   input wire logic fifo_push_out,
   input wire logic [7:0] fifo_data_out,
   input wire logic force_full_ask_out,
   input wire logic antenna_drive_1_oe_out,
   input wire logic antenna_drive_2_oe_out
);
   logic multi_q;
   logic [1:0] src_q;
   logic [7:0] eb_q;
   logic [7:0] eb_d;
   logic fe;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // A frame end with no competing start, command or register write.
   assign fe = rx_enable_out && rx_frame_end_in && !rx_start_in && !reg_wr_in && !command_write_in;
   always_comb begin
      eb_d = error_register_in;
      eb_d[CRC_BIT_POS] = DEVICE_REVISION ? crc_good_flag_in : crc_fail_flag_in;
   end
   always_ff @(posedge mclk_in) begin
      eb_q <= eb_d;
      if (!rst_n_in) begin
         multi_q <= 1'b0;
         src_q <= 2'h1;
      end else if (reg_wr_in && reg_addr_in == 6'h13) begin
         multi_q <= reg_wdata_in[2];
      end else if (reg_wr_in && reg_addr_in == 6'h16) begin
         src_q <= reg_wdata_in[5:4];
      end
   end
   unmapped_read_a: assert property (reg_rd_in && !(reg_addr_in inside {[6'h13:6'h16]})
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
   reserved_bit_a: assert property (reg_rd_in && reg_addr_in == 6'h14
      |=> !reg_rdata_out[2]) else $error("reserved control bit read as one");
   ask_mirror_a: assert property (reg_rd_in && reg_addr_in == 6'h15 && !reg_wr_in
      |=> reg_rdata_out[6] == force_full_ask_out) else $error("full ask output mismatch");
   rx_open_a: assert property (rx_start_in |=> rx_enable_out)
      else $error("receiver not started");
   single_stop_a: assert property (fe && !multi_q |=> !rx_enable_out && rx_done_out)
      else $error("receiver not stopped after one frame");
   multi_keep_a: assert property (fe && multi_q
      |=> rx_enable_out && fifo_push_out && !rx_done_out) else $error("multi frame push wrong");
   err_byte_a: assert property (fe && multi_q |=> fifo_data_out == eb_q)
      else $error("error byte content wrong");
   cmd_stop_a: assert property (rx_enable_out && command_write_in
      && !command_is_receive_in && !rx_start_in |=> !rx_enable_out && rx_done_out)
      else $error("command did not stop");
   cmd_recv_a: assert property (rx_enable_out && command_write_in
      && command_is_receive_in && multi_q && !reg_wr_in |=> rx_enable_out)
      else $error("receive command stopped rx");
   clear_stop_a: assert property (rx_enable_out && multi_q && reg_wr_in && !rx_start_in
      && reg_addr_in == 6'h13 && !reg_wdata_in[2] |=> !rx_enable_out && rx_done_out)
      else $error("multi frame clear did not stop");
   // The pin enables are one register behind the source field, so the edge after reset is skipped.
   drv_float_a: assert property ($past(rst_n_in) |->
      antenna_drive_1_oe_out == ($past(src_q) != 2'h0)
      && antenna_drive_2_oe_out == antenna_drive_1_oe_out)
      else $error("driver enable wrong");
endmodule
bind rfdrv_regs rfdrv_regs_sva #(.DEVICE_REVISION(DEVICE_REVISION),
   .CRC_BIT_POS(CRC_BIT_POS)) u_sva (
   .mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
   .rx_start_in, .rx_frame_end_in, .command_write_in, .command_is_receive_in, .error_register_in,
   .crc_good_flag_in, .crc_fail_flag_in, .rx_enable_out, .rx_done_out, .fifo_push_out,
   .fifo_data_out, .force_full_ask_out, .antenna_drive_1_oe_out, .antenna_drive_2_oe_out);

// File: dv/tb_rfdrv_regs.sv
`timescale 1ns/1ps
module tb_rfdrv_regs;
   logic mclk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic rx_start_in = 1'b0, rx_frame_end_in = 1'b0, command_write_in = 1'b0;
   logic command_is_receive_in = 1'b0, soft_powerdown_in = 1'b0, miller_env_in = 1'b0;
   logic crc_good_flag_in = 1'b0, crc_fail_flag_in = 1'b0, aux_envelope_in = 1'b0;
   logic tx_serial_in = 1'b0, rx_decoded_in = 1'b0, test_bus_in = 1'b0;
   logic [5:0] reg_addr_in = 6'h00;
   logic [7:0] reg_wdata_in = 8'h00, error_register_in = 8'h00;
   logic [7:0] reg_rdata_out, fifo_data_out, ctl, sel;
   logic rx_enable_out, rx_done_out, fifo_push_out, force_full_ask_out, aux_out_pin_out;
   logic antenna_drive_1_out, antenna_drive_1_oe_out, antenna_drive_2_out, antenna_drive_2_oe_out;
   logic aux_out_pin_oe_out;
   logic [1:0] e1, e2, ea;
   int fails = 0, n_compared = 0, cyc = 0;
   rfdrv_regs u_dut (.mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .rx_start_in, .rx_frame_end_in, .command_write_in, .command_is_receive_in,
      .error_register_in, .crc_good_flag_in, .crc_fail_flag_in, .soft_powerdown_in,
      .miller_env_in, .aux_envelope_in, .tx_serial_in, .rx_decoded_in, .test_bus_in,
      .rx_enable_out, .rx_done_out, .fifo_push_out, .fifo_data_out, .force_full_ask_out,
      .antenna_drive_1_out, .antenna_drive_1_oe_out, .antenna_drive_2_out,
      .antenna_drive_2_oe_out, .aux_out_pin_out, .aux_out_pin_oe_out);
   always #5 mclk_in = ~mclk_in;
   task tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         tally_and_finish();
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
         fails++;
      end
   endtask
   // A floating output has no defined level, so the level is only compared while driven.
   task pchk(input logic oe, input logic lv, input logic [1:0] e, input string m);
      chk({6'h00, oe, oe & lv}, {6'h00, e[1], e[1] & e[0]}, m);
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge mclk_in);
      reg_wr_in = 1'b0;
   endtask
   task rd(input logic [5:0] a, input logic [7:0] e);
      @(negedge mclk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge mclk_in);
      reg_rd_in = 1'b0;
      chk(reg_rdata_out, e, "read");
   endtask
   function logic [7:0] keep(input logic [5:0] a, input logic [7:0] d);
      case (a)
         6'h13: return d & 8'h04;
         6'h14: return d & 8'hfb;
         6'h15: return d & 8'h40;
         6'h16: return d & 8'h3f;
         default: return 8'h00;
      endcase
   endfunction
   function logic [1:0] pin(input logic en, on, off, cw, input logic [1:0] s);
      logic env;
      env = (s == 2'h1) ? miller_env_in : (s == 2'h2) ? aux_envelope_in : 1'b1;
      return {s != 2'h0, (en & (cw | env)) ^ (en ? on : off)};
   endfunction
   function logic [1:0] auxp(input logic [3:0] c);
      case (c)
         4'h1: return 2'b10;
         4'h2: return 2'b11;
         4'h3: return {1'b1, test_bus_in};
         4'h4: return {1'b1, miller_env_in};
         4'h5: return {1'b1, tx_serial_in};
         4'h7: return {1'b1, rx_decoded_in};
         default: return 2'b00;
      endcase
   endfunction
   task frame(input logic [2:0] e);
      logic [7:0] eb;
      @(negedge mclk_in);
      error_register_in = 8'($urandom);
      {crc_good_flag_in, crc_fail_flag_in} = 2'($urandom);
      rx_frame_end_in = 1'b1;
      eb = error_register_in;
      eb[2] = crc_good_flag_in;
      @(negedge mclk_in);
      rx_frame_end_in = 1'b0;
      chk({5'h00, fifo_push_out, rx_enable_out, rx_done_out}, {5'h00, e}, "frame end");
      if (e[2]) chk(fifo_data_out, eb, "error byte");
   endtask
   task start();
      @(negedge mclk_in);
      rx_start_in = 1'b1;
      @(negedge mclk_in);
      rx_start_in = 1'b0;
      chk({7'h00, rx_enable_out}, 8'h01, "start");
   endtask
   task cmd(input logic recv);
      @(negedge mclk_in);
      command_write_in = 1'b1;
      command_is_receive_in = recv;
      @(negedge mclk_in);
      command_write_in = 1'b0;
      chk({6'h00, rx_enable_out, rx_done_out}, {6'h00, recv, !recv}, "command");
   endtask
   initial begin
      void'($urandom(83));
      repeat (3) @(negedge mclk_in);
      rst_n_in = 1'b1;
      for (int a = 6'h12; a < 6'h18; a++) begin
         rd(6'(a), (a == 6'h14) ? 8'h80 : (a == 6'h16) ? 8'h10 : 8'h00);
      end
      for (int i = 0; i < 24; i++) begin
         ctl = 8'($urandom);
         sel = 8'h13 + 8'($urandom % 5);
         wr(sel[5:0], ctl);
         rd(sel[5:0], keep(sel[5:0], ctl));
         if (sel == 8'h15) chk({7'h00, force_full_ask_out}, {7'h00, ctl[6]}, "ask");
      end
      for (int i = 0; i < 48; i++) begin
         ctl = 8'($urandom);
         sel = {2'b00, 2'(i), 4'($urandom)};
         wr(6'h14, ctl);
         wr(6'h16, sel);
         {miller_env_in, aux_envelope_in, tx_serial_in} = 3'($urandom);
         {rx_decoded_in, test_bus_in, soft_powerdown_in} = 3'($urandom);
         repeat (4) @(negedge mclk_in);
         e1 = pin(ctl[0], ctl[6], ctl[4], 1'b0, sel[5:4]);
         e2 = pin(ctl[1], ctl[7], ctl[5], ctl[3], sel[5:4]);
         ea = auxp(sel[3:0]);
         pchk(antenna_drive_1_oe_out, antenna_drive_1_out, e1,
            "drv1");
         pchk(antenna_drive_2_oe_out, antenna_drive_2_out, e2,
            "drv2");
         pchk(aux_out_pin_oe_out, aux_out_pin_out, ea, "aux");
      end
      wr(6'h13, 8'h00);
      frame(3'b000);
      start();
      frame(3'b001);
      wr(6'h13, 8'hff);
      start();
      repeat (4) frame(3'b110);
      cmd(1'b1);
      frame(3'b110);
      cmd(1'b0);
      start();
      wr(6'h13, 8'h00);
      chk({6'h00, rx_enable_out, rx_done_out}, 8'h01, "clear stop");
      tally_and_finish();
   end
endmodule
